// ==== rtl/prof_pkg.sv ====
package prof_pkg;

	localparam int FEAT_BIT = 62;
	localparam int REGION_BYTES = 128;
	localparam int REGION_OFFSET = 832;
	localparam int NUM_EVENTS = 6;
	localparam logic [31:0] RECORD_SIZE = 32'h00000020;
	localparam logic [31:0] MIN_BUF_SIZE = 32'h00000040;
	localparam logic [31:0] CB_SIZE = 32'h00000080;
	localparam logic [27:0] SIZE_MASK = 28'hFFFFFFF;
	localparam logic [7:0] PEND_ID_LSB = 8'h00;

	typedef struct packed {
		logic [63:0] cb_addr;
		logic [5:0] cntr_flags;
		logic [31:0] head_off;
		logic [63:0] buf_base;
		logic [27:0] buf_size;
		logic [31:0] filters;
		logic [255:0] pend_rec;
		logic [6*32-1:0] counters;
	} area_s;

	typedef struct packed {
		logic [31:0] base;
		logic [31:0] limit;
		logic read_only;
		logic long_mode;
		logic [1:0] current_privilege_level;
	} seg_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PTRS = 3'b001,
		ST_EVTS = 3'b010,
		ST_PEND = 3'b011,
		ST_DONE = 3'b100
	} state_e;

endpackage

// ==== rtl/profiler_state_save_restore.sv ====
// Functional notes
// [R1] save with block address zero writes nothing and clears header bit 62
// [R2] save while enabled copies state unchanged and sets header bit 62
// [R3] restore leaves state alone if feature bit or mask bit 62 is zero
// [R4] header bit 62 zero on restore clears block address, disabling profiler
// [R5] default restore zeroes all other internal state too
// [R6] buffer size below minimum disables profiler and ends restore
// [R7] buffer size and head offset rounded down to record size multiple
// [R8] head offset beyond size minus record size becomes zero
// [R9] flagged and configured events enabled with counters loaded, others off
// [R10] non-zero pending record reloaded, stored once privilege is 3
// [R11] pending records not made by save may be discarded
// [R12] restore overwrites running state without saving it
// [R13] restore never raises threshold interrupt
// [R14] unrestored state fetched from control block at next record store
// [R15] privilege 0 reloads addresses without validation
// [R16] nonzero privilege checks both ranges, segment-relative outside 64-bit mode
// [R17] store check fails beyond limit or on read-only segment
// [R18] failed check disables profiler silently
// [R19] feature bit zero with header bit one raises protection fault
// [R20] several events counted, records may be stored for only some
// [R21] counters kept in internal hardware
// [R22] no lazy switching, task-switched bit ignored
// [R23] region is 128 bytes at offset 832
// [R24] event identifier zero means no pending record
// [R25] restore steps ordered: pointers, events, pending record
`timescale 1ns/1ps
module profiler_state_save_restore
	import prof_pkg::*;
#(
	parameter int NEV = NUM_EVENTS
)(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic save_i,
	input wire logic restore_i,
	input wire logic [63:0] feature_enable_control_reg_i,
	input wire logic [63:0] feature_enable_mask_i,
	input wire logic [63:0] header_state_vector_i,
	input wire area_s area_i,
	input wire seg_s seg_i,
	input wire logic [NEV-1:0] profiler_config_reg_i,
	input wire logic record_stored_i,
	input wire logic [NEV-1:0] event_hit_i,
	output logic [63:0] control_block_address_reg_o,
	output logic [63:0] buf_base_o,
	output logic [27:0] ring_buffer_size_o,
	output logic [31:0] ring_head_offset_o,
	output logic [NEV-1:0] event_enable_o,
	output logic [NEV*32-1:0] event_counter_o,
	output logic [255:0] pending_record_o,
	output logic pending_valid_o,
	output logic pending_write_o,
	output logic fetch_block_o,
	output logic save_valid_o,
	output area_s area_o,
	output logic header_bit_o,
	output logic general_protection_fault_o,
	output logic busy_o
);

	// ****************************************
	// decode
	// ****************************************
	state_e st_q;
	state_e st_d;
	area_s ld_q;
	logic [1:0] cpl_q;
	wire logic feat_en = feature_enable_control_reg_i[FEAT_BIT];
	wire logic mask_en = feature_enable_mask_i[FEAT_BIT];
	wire logic hdr_en = header_state_vector_i[FEAT_BIT];
	wire logic go = restore_i && st_q == ST_IDLE;
	wire logic fault = go && !feat_en && hdr_en; // [R19]
	wire logic skip = go && (!feat_en || !mask_en); // [R3]
	wire logic dflt = go && feat_en && mask_en && !hdr_en; // [R4]
	wire logic full = go && feat_en && mask_en && hdr_en;
	wire logic [31:0] bsz32 = {4'h0, ld_q.buf_size};
	wire logic [31:0] bsz_rnd = bsz32 - (bsz32 % RECORD_SIZE); // [R7]
	wire logic [31:0] hd_rnd = ld_q.head_off - (ld_q.head_off % RECORD_SIZE); // [R7]
	wire logic hd_over = ld_q.head_off > (bsz_rnd - RECORD_SIZE); // [R8]
	wire logic too_small = bsz32 < MIN_BUF_SIZE; // [R6]

	// ****************************************
	// segment check
	// ****************************************
	function automatic logic seg_ok(input logic [63:0] a, input logic [31:0] sz, input seg_s s);
		logic [63:0] lo;
		logic [63:0] top;
		lo = a;
		if (!s.long_mode) // [R16]
			lo = {32'h0, 32'(a - {32'h0, s.base})};
		top = lo + {32'h0, sz} - 64'h1;
		if (!s.long_mode)
			top = {32'h0, top[31:0]};
		seg_ok = !s.read_only && lo <= {32'h0, s.limit} && top <= {32'h0, s.limit}; // [R17]
	endfunction

	wire logic addr_ok = (cpl_q == 2'h0) || // [R15]
		(seg_ok(ld_q.cb_addr, CB_SIZE, seg_i) && seg_ok(ld_q.buf_base, bsz32, seg_i)); // [R16]
	wire logic pend_nz = ld_q.pend_rec[7:0] != PEND_ID_LSB; // [R24]

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: st_d = full ? ST_PTRS : ST_IDLE;
			ST_PTRS: st_d = (too_small || !addr_ok) ? ST_DONE : ST_EVTS; // [R25]
			ST_EVTS: st_d = ST_PEND;
			ST_PEND: st_d = ST_DONE;
			ST_DONE: st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end

	// ****************************************
	// state registers
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			st_q <= ST_IDLE;
			ld_q <= '0;
			cpl_q <= 2'h0;
			general_protection_fault_o <= 1'b0;
			busy_o <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			busy_o <= st_d != ST_IDLE;
			general_protection_fault_o <= fault;
			if (full)
			begin
				ld_q <= area_i;
				cpl_q <= seg_i.current_privilege_level;
			end
		end
	end

	// [R12] [R21] [R22] profiler state overwritten directly, no lazy path
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || (dflt && !skip)) // [R5]
		begin
			control_block_address_reg_o <= 64'h0;
			buf_base_o <= 64'h0;
			ring_buffer_size_o <= 28'h0;
			ring_head_offset_o <= 32'h0;
			event_enable_o <= '0;
			pending_record_o <= '0;
			pending_valid_o <= 1'b0;
			fetch_block_o <= 1'b0;
		end
		else
		begin
			case (st_q)
				ST_PTRS:
				begin
					if (too_small || !addr_ok) // [R6] [R18]
					begin
						control_block_address_reg_o <= 64'h0;
						event_enable_o <= '0;
						pending_valid_o <= 1'b0;
					end
					else
					begin
						control_block_address_reg_o <= ld_q.cb_addr;
						buf_base_o <= ld_q.buf_base;
						ring_buffer_size_o <= bsz_rnd[27:0] & SIZE_MASK;
						ring_head_offset_o <= hd_over ? 32'h0 : hd_rnd; // [R8]
					end
				end
				ST_EVTS:
					event_enable_o <= ld_q.cntr_flags[NEV-1:0] & profiler_config_reg_i; // [R9]
				ST_PEND:
				begin
					pending_record_o <= ld_q.pend_rec; // [R11]
					pending_valid_o <= pend_nz; // [R10]
					fetch_block_o <= 1'b1; // [R14]
				end
				default:
				begin
					if (pending_write_o)
						pending_valid_o <= 1'b0;
					if (record_stored_i)
						fetch_block_o <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// counters and pending write
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NEV; g++)
		begin : gen_cnt
			always_ff @(posedge clk_i)
			begin
				if (!rst_n_i || dflt)
					event_counter_o[g*32 +: 32] <= 32'h0;
				else if (st_q == ST_EVTS)
					event_counter_o[g*32 +: 32] <= (ld_q.cntr_flags[g] && profiler_config_reg_i[g])
						? ld_q.counters[g*32 +: 32] : 32'h0; // [R9]
				else if (event_enable_o[g] && event_hit_i[g]) // [R20]
					event_counter_o[g*32 +: 32] <= event_counter_o[g*32 +: 32] - 32'h1;
			end
		end
	endgenerate

	// [R13] no threshold interrupt source exists in the restore path
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			pending_write_o <= 1'b0;
		else
			pending_write_o <= pending_valid_o && !pending_write_o && seg_i.current_privilege_level == 2'h3; // [R10]
	end

	// ****************************************
	// save
	// ****************************************
	wire logic prof_on = control_block_address_reg_o != 64'h0;
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			save_valid_o <= 1'b0;
			header_bit_o <= 1'b0;
			area_o <= '0;
		end
		else
		begin
			save_valid_o <= save_i;
			if (save_i)
			begin
				header_bit_o <= prof_on; // [R1] [R2]
				if (prof_on) // [R2] [R23]
					area_o <= '{control_block_address_reg_o, event_enable_o, ring_head_offset_o,
						buf_base_o, ring_buffer_size_o, 32'h0,
						pending_valid_o ? pending_record_o : 256'h0, event_counter_o};
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	fault_gp_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		restore_i && st_q == ST_IDLE && !feat_en && hdr_en |=> general_protection_fault_o)
		else $error("missing protection fault"); // [R19]
	save_hdr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		save_i |=> header_bit_o == $past(prof_on))
		else $error("header bit wrong"); // [R1]
	dflt_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		dflt |=> control_block_address_reg_o == 64'h0 && event_enable_o == '0)
		else $error("default not applied"); // [R4]
	skip_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		skip |=> $stable(control_block_address_reg_o))
		else $error("state altered"); // [R3]
	small_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		st_q == ST_PTRS && too_small |=> control_block_address_reg_o == 64'h0 ##1 !pending_valid_o)
		else $error("small buffer kept"); // [R6]
	head_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		st_q == ST_PTRS && !too_small && addr_ok && hd_over |=> ring_head_offset_o == 32'h0)
		else $error("head not zeroed"); // [R8]
	round_size_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		st_q == ST_PTRS && !too_small && addr_ok |=> ring_buffer_size_o[4:0] == 5'h0)
		else $error("size not rounded"); // [R7]
	evt_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		st_q == ST_EVTS |=> (event_enable_o & ~$past(profiler_config_reg_i)) == '0)
		else $error("unavailable event on"); // [R9]
	fail_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		st_q == ST_PTRS && !addr_ok |=> control_block_address_reg_o == 64'h0 && !general_protection_fault_o)
		else $error("bad address kept"); // [R18]

endmodule

// ==== testbench/profiler_state_save_restore_tb.sv ====
`timescale 1ns/1ps
module profiler_state_save_restore_tb import prof_pkg::*;;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
	localparam logic [63:0] B62 = 64'h4000000000000000;
	typedef struct {int k; logic [255:0] v;} note_s;
	logic clk_i = 1'b0, rst_n_i = 1'b0, save_i = 1'b0, restore_i = 1'b0;
	logic [63:0] fe = '0, mk = '0, hd = '0, cb_o;
	area_s area = '0;
	seg_s seg = '0;
	logic [5:0] cfg = '0, en_o;
	logic [27:0] sz_o;
	logic [31:0] hd_o;
	logic [191:0] ct_o, cmask;
	logic [255:0] pr_o;
	logic pv_o, sv_o, hb_o, gp_o;
	note_s q[$];
	int fails = 0, n_compared = 0, cyc = 0;
	event probe;
	profiler_state_save_restore dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .save_i(save_i),
		.restore_i(restore_i), .feature_enable_control_reg_i(fe), .feature_enable_mask_i(mk),
		.header_state_vector_i(hd), .area_i(area), .seg_i(seg), .profiler_config_reg_i(cfg),
		.record_stored_i(1'b0), .event_hit_i(6'h00), .control_block_address_reg_o(cb_o),
		.buf_base_o(), .ring_buffer_size_o(sz_o), .ring_head_offset_o(hd_o),
		.event_enable_o(en_o), .event_counter_o(ct_o), .pending_record_o(pr_o),
		.pending_valid_o(pv_o), .pending_write_o(), .fetch_block_o(), .save_valid_o(sv_o),
		.area_o(), .header_bit_o(hb_o), .general_protection_fault_o(gp_o), .busy_o());
	always #5 clk_i = ~clk_i;
	function automatic logic [255:0] got(int k);
		case (k)
			0: return 256'(hb_o);
			1: return 256'(cb_o);
			2: return 256'(sz_o);
			3: return 256'(hd_o);
			4: return 256'(en_o);
			5: return 256'(ct_o & cmask);
			6: return 256'(pv_o);
			7: return 256'(gp_o);
			default: return pr_o;
		endcase
	endfunction
	task automatic note(int k, logic [255:0] v);
		q.push_back('{k, v});
	endtask
	task automatic cmp();
		note_s n;
		n = q.pop_front();
		`CHK(got(n.k), n.v)
	endtask
	// ****************
	// result watcher
	// ****************
	always @(posedge clk_i)
		if (rst_n_i && q.size() > 0 && (sv_o === 1'b1 || gp_o === 1'b1))
			cmp();
	always @(probe)
		while (q.size() > 0)
			cmp();
	// ****************
	// drivers
	// ****************
	task automatic setb(logic [63:0] f, logic [63:0] m, logic [63:0] h);
		@(posedge clk_i);
		fe <= f;
		mk <= m;
		hd <= h;
	endtask
	task automatic op(bit s, string nm);
		@(posedge clk_i);
		if (s)
			save_i <= 1'b1;
		else
			restore_i <= 1'b1;
		@(posedge clk_i);
		save_i <= 1'b0;
		restore_i <= 1'b0;
		repeat (7) @(posedge clk_i);
		#1;
		-> probe;
		#1;
		$display("test %0s done", nm);
	endtask
	task automatic full(logic [63:0] cb, logic [27:0] sz, logic [31:0] ho, logic [7:0] id, bit ok);
		area_s a;
		logic [5:0] c;
		logic [27:0] rs;
		a = '0;
		a.cb_addr = cb;
		a.buf_base = 64'h0000000000008000;
		a.buf_size = sz;
		a.head_off = ho;
		a.cntr_flags = 6'($urandom);
		a.pend_rec = {224'h0, 32'($urandom)};
		a.pend_rec[7:0] = id;
		for (int i = 0; i < 6; i++)
			a.counters[i*32 +: 32] = $urandom;
		c = 6'($urandom);
		for (int i = 0; i < 6; i++)
			cmask[i*32 +: 32] = {32{a.cntr_flags[i] & c[i]}};
		rs = sz & ~28'h000001F;
		@(posedge clk_i);
		area <= a;
		cfg <= c;
		note(1, ok ? cb : 64'h0);
		if (ok)
		begin
			note(2, rs);
			note(3, (ho > 32'(rs) - RECORD_SIZE) ? 32'h0 : ho & ~32'h0000001F);
			note(4, a.cntr_flags & c);
			note(5, a.counters & cmask);
			// record drained once privilege is 3, so valid drops after the write pulse
			note(6, id != 8'h00 && seg.current_privilege_level != 2'd3);
			if (id != 8'h00)
				note(8, a.pend_rec);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	initial
	begin
		void'($urandom(21469));
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		note(0, 0);
		op(1, "save_off");
		setb(B62, B62, B62);
		full(64'h1000, 28'h0000105, 32'hF1, 8'h5A, 1);
		op(0, "full");
		note(0, 1);
		op(1, "save_on");
		full(64'h3000, 28'h0000100, 32'h45, 8'h00, 1);
		op(0, "overwrite");
		setb(B62, 0, B62);
		note(1, 64'h3000);
		op(0, "mask_off");
		setb(0, B62, 0);
		note(1, 64'h3000);
		op(0, "feature_off");
		setb(0, B62, B62);
		note(7, 1);
		note(1, 64'h3000);
		op(0, "fault");
		setb(B62, B62, B62);
		full(64'h3000, 28'h0000020, 32'h0, 8'h00, 0);
		op(0, "small");
		full(64'h3000, 28'h0000100, 32'h0, 8'h11, 1);
		op(0, "reload");
		setb(B62, B62, 0);
		note(1, 0);
		note(4, 0);
		note(6, 0);
		op(0, "default");
		setb(B62, B62, B62);
		for (int j = 0; j < 3; j++)
		begin
			@(posedge clk_i);
			seg <= (j == 0) ? {32'h0, 32'hFFFFFFFF, 1'b1, 1'b1, 2'd3} :
				(j == 1) ? {32'h0, 32'h1000, 1'b0, 1'b1, 2'd3} :
				{32'h1000, 32'hFFFFFFFF, 1'b0, 1'b0, 2'd3};
			full(64'h3000, 28'h0000100, 32'h0, 8'h11, j == 2);
			op(0, "segment");
		end
		tally_and_finish();
	end
endmodule
